// ### verilog/sensor_pkg.sv
package sensor_pkg;

	// ----------------------------------------------------------------
	// sensor register map and command values
	// ----------------------------------------------------------------
	localparam logic [6:0] SLAVE_ADDR   = 7'h6d;
	localparam logic [7:0] REG_P_HIGH   = 8'h06;
	localparam logic [7:0] REG_P_MID    = 8'h07;
	localparam logic [7:0] REG_P_LOW    = 8'h08;
	localparam logic [7:0] REG_T_HIGH   = 8'h09;
	localparam logic [7:0] REG_T_LOW    = 8'h0a;
	localparam logic [7:0] REG_CMD      = 8'h30;
	localparam logic [7:0] CMD_RESET    = 8'h00;
	localparam logic [7:0] CMD_COMBINED = 8'h0a;
	localparam int         SCO_BIT      = 3;
	localparam logic [2:0] MEAS_COMB    = 3'b010;
	localparam logic [2:0] MEAS_SLEEP   = 3'b011;
	localparam logic [2:0] LAST_RESULT  = 3'd4;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ      = 40_000_000;
	localparam int WAIT_MS     = 20;
	localparam int WAIT_CYC    = WAIT_MS * (CLK_HZ / 1000);
	// short bit keeps runs brief; two quarters low still clear the scl minimum
	localparam int QUARTER_NS  = 750;
	localparam int QUARTER_CYC = QUARTER_NS * (CLK_HZ / 1_000_000) / 1000;
	localparam int CONV_US     = 5;
	localparam int CONV_CYC    = CONV_US * (CLK_HZ / 1_000_000);

	// ----------------------------------------------------------------
	// host software port
	// ----------------------------------------------------------------
	localparam logic [4:0] A_CTRL    = 5'h00;
	localparam logic [4:0] A_STATUS  = 5'h04;
	localparam logic [4:0] A_PRAW    = 5'h08;
	localparam logic [4:0] A_PPA     = 5'h0c;
	localparam logic [4:0] A_TRAW    = 5'h10;
	localparam logic [4:0] A_TDEG    = 5'h14;
	localparam int         CTRL_GO   = 0;
	localparam int         CTRL_WAIT = 1;
	localparam int         CTRL_SH   = 2;
	localparam logic [3:0] SHIFT_RST = 4'h6;
	localparam int         ST_DONE   = 1;
	localparam int         ST_NACK   = 2;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {OP_START, OP_TX, OP_RX, OP_STOP} op_t;
	typedef enum logic {B_IDLE = 1'b0, B_RUN = 1'b1} b_state_t;
	typedef enum logic [2:0] {
		C_IDLE = 3'b000, C_CMD = 3'b001, C_POLL = 3'b011,
		C_WAIT = 3'b010, C_READ = 3'b110, C_END = 3'b111
	} c_state_t;
	typedef enum logic [1:0] {
		D_IDLE = 2'b00, D_ADDR = 2'b01, D_REG = 2'b11, D_DATA = 2'b10
	} d_state_t;

	// ----------------------------------------------------------------
	// transaction programs
	// ----------------------------------------------------------------
	function automatic op_t op_of(logic rd, logic [2:0] step);
		case (step)
			3'd0: op_of = OP_START;
			3'd1, 3'd2: op_of = OP_TX;
			3'd3: op_of = rd ? OP_START : OP_TX;
			3'd4: op_of = rd ? OP_TX : OP_STOP;
			3'd5: op_of = OP_RX;
			default: op_of = OP_STOP;
		endcase
	endfunction : op_of

	function automatic logic [7:0] tx_byte(logic rd, logic [2:0] step,
		logic [7:0] rg);
		case (step)
			3'd1: tx_byte = {SLAVE_ADDR, 1'b0};
			3'd2: tx_byte = rg;
			3'd3: tx_byte = CMD_COMBINED;
			3'd4: tx_byte = {SLAVE_ADDR, 1'b1};
			default: tx_byte = 8'h00;
		endcase
		if (!rd && step == 3'd4)
			tx_byte = 8'h00;
	endfunction : tx_byte

endpackage : sensor_pkg

// ### verilog/sensor_link_if.sv
`timescale 1ns/1ps
interface sensor_link_if;
	logic scl;
	logic sda;
	logic h_scl_o;
	logic h_scl_oe;
	logic h_sda_o;
	logic h_sda_oe;
	logic d_sda_o;
	logic d_sda_oe;

	// open-drain wired-and with pull-ups
	assign scl = !(h_scl_oe && !h_scl_o);
	assign sda = !((h_sda_oe && !h_sda_o) || (d_sda_oe && !d_sda_o));

	modport host (output h_scl_o, h_scl_oe, h_sda_o, h_sda_oe,
		input scl, sda);
	modport dev (output d_sda_o, d_sda_oe, input scl, sda);
endinterface : sensor_link_if

// ### verilog/tick_gen.sv
`timescale 1ns/1ps
module tick_gen #(
	parameter int DIV = 100
) (
	// system
	input  wire logic clock,
	input  wire logic rst,
	// enable pulse
	output logic      tick
);
	logic [15:0] cnt_q;
	logic        tick_q;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cnt_q  <= 16'h0000;
			tick_q <= 1'b0;
		end else if (cnt_q == 16'(DIV - 1)) begin
			cnt_q  <= 16'h0000;
			tick_q <= 1'b1;
		end else begin
			cnt_q  <= cnt_q + 16'h0001;
			tick_q <= 1'b0;
		end
	end

	assign tick = tick_q;
endmodule : tick_gen

// ### verilog/sensor_dev.sv
`timescale 1ns/1ps
module sensor_dev (
	// system
	input  wire logic        clock,
	input  wire logic        rst,
	// two-wire link
	sensor_link_if.dev       link,
	// measured values
	input  wire logic [23:0] pressure_in,
	input  wire logic [15:0] temperature_in,
	// status
	output logic             sco_flag
);
	sensor_pkg::d_state_t st_q;
	logic        rd_q;
	logic        ackph_q;
	logic        first_q;
	logic        mack_q;
	logic [3:0]  cnt_q;
	logic [7:0]  sr_q;
	logic [7:0]  tx_q;
	logic [7:0]  ptr_q;
	logic        sda_oe_q;
	logic        scl_p_q;
	logic        sda_p_q;
	logic [7:0]  cmd_q;
	logic [23:0] press_q;
	logic [15:0] temp_q;
	logic [7:0]  conv_q;

	// ----------------------------------------------------------------
	// line events
	// ----------------------------------------------------------------
	wire scl_rise = link.scl && !scl_p_q;
	wire scl_fall = !link.scl && scl_p_q;
	wire start_c  = link.scl && scl_p_q && sda_p_q && !link.sda;
	wire stop_c   = link.scl && scl_p_q && !sda_p_q && link.sda;
	wire byte_end = scl_fall && !ackph_q && cnt_q == 4'd8;
	wire cmd_wr   = byte_end && st_q == sensor_pkg::D_DATA && !rd_q
		&& ptr_q == sensor_pkg::REG_CMD;
	wire mode_ok  = sr_q[2:0] == sensor_pkg::MEAS_COMB
		|| sr_q[2:0] == sensor_pkg::MEAS_SLEEP;
	wire addr_hit = sr_q[7:1] == sensor_pkg::SLAVE_ADDR;
	wire [7:0] rd_byte =
		ptr_q == sensor_pkg::REG_P_HIGH ? press_q[23:16] :
		ptr_q == sensor_pkg::REG_P_MID  ? press_q[15:8]  :
		ptr_q == sensor_pkg::REG_P_LOW  ? press_q[7:0]   :
		ptr_q == sensor_pkg::REG_T_HIGH ? temp_q[15:8]   :
		ptr_q == sensor_pkg::REG_T_LOW  ? temp_q[7:0]    :
		ptr_q == sensor_pkg::REG_CMD    ? cmd_q          :
		8'h00;

	// ----------------------------------------------------------------
	// slave bit engine
	// ----------------------------------------------------------------
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			st_q     <= sensor_pkg::D_IDLE;
			rd_q     <= 1'b0;
			ackph_q  <= 1'b0;
			first_q  <= 1'b0;
			mack_q   <= 1'b0;
			cnt_q    <= 4'h0;
			sr_q     <= 8'h00;
			tx_q     <= 8'h00;
			ptr_q    <= 8'h00;
			sda_oe_q <= 1'b0;
			scl_p_q  <= 1'b1;
			sda_p_q  <= 1'b1;
		end else begin
			scl_p_q <= link.scl;
			sda_p_q <= link.sda;
			if (start_c) begin
				st_q     <= sensor_pkg::D_ADDR;
				rd_q     <= 1'b0;
				cnt_q    <= 4'h0;
				ackph_q  <= 1'b0;
				sda_oe_q <= 1'b0;
			end else if (stop_c) begin
				st_q     <= sensor_pkg::D_IDLE;
				sda_oe_q <= 1'b0;
			end else if (st_q != sensor_pkg::D_IDLE) begin
				if (scl_rise && ackph_q)
					mack_q <= !link.sda;
				if (scl_rise && !ackph_q) begin
					sr_q  <= {sr_q[6:0], link.sda};
					cnt_q <= cnt_q + 4'h1;
				end
				if (scl_fall && ackph_q) begin
					ackph_q <= 1'b0;
					cnt_q   <= 4'h0;
					if (rd_q && (first_q || mack_q)) begin
						tx_q     <= rd_byte;
						ptr_q    <= ptr_q + 8'h01;
						sda_oe_q <= !rd_byte[7];
						first_q  <= 1'b0;
					end else begin
						sda_oe_q <= 1'b0;
						if (rd_q)
							st_q <= sensor_pkg::D_IDLE;
					end
				end else if (byte_end) begin
					ackph_q <= 1'b1;
					case (st_q)
						sensor_pkg::D_ADDR: begin
							sda_oe_q <= addr_hit;
							rd_q     <= sr_q[0];
							first_q  <= sr_q[0];
							if (!addr_hit)
								st_q <= sensor_pkg::D_IDLE;
							else if (sr_q[0])
								st_q <= sensor_pkg::D_DATA;
							else
								st_q <= sensor_pkg::D_REG;
						end
						sensor_pkg::D_REG: begin
							ptr_q    <= sr_q;
							sda_oe_q <= 1'b1;
							st_q     <= sensor_pkg::D_DATA;
						end
						default: begin
							sda_oe_q <= !rd_q;
							if (!rd_q)
								ptr_q <= ptr_q + 8'h01;
						end
					endcase
				end else if (scl_fall && rd_q && st_q == sensor_pkg::D_DATA)
					sda_oe_q <= !tx_q[3'd7 - cnt_q[2:0]];
			end
		end
	end

	// ----------------------------------------------------------------
	// conversion
	// ----------------------------------------------------------------
	// sleep mode restarts back to back; the sleep interval is not modelled
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cmd_q   <= sensor_pkg::CMD_RESET;
			conv_q  <= 8'h00;
			press_q <= 24'h000000;
			temp_q  <= 16'h0000;
		end else if (cmd_wr) begin
			cmd_q <= sr_q;
			if (!mode_ok)
				cmd_q[sensor_pkg::SCO_BIT] <= 1'b0;
			if (sr_q[sensor_pkg::SCO_BIT] && mode_ok)
				conv_q <= 8'(sensor_pkg::CONV_CYC);
		end else if (conv_q != 8'h00) begin
			conv_q <= conv_q - 8'h01;
			if (conv_q == 8'h01) begin
				press_q <= pressure_in;
				temp_q  <= temperature_in;
				if (cmd_q[2:0] == sensor_pkg::MEAS_SLEEP)
					conv_q <= 8'(sensor_pkg::CONV_CYC);
				else
					cmd_q[sensor_pkg::SCO_BIT] <= 1'b0;
			end
		end
	end

	assign link.d_sda_o  = 1'b0;
	assign link.d_sda_oe = sda_oe_q;
	assign sco_flag      = cmd_q[sensor_pkg::SCO_BIT];
endmodule : sensor_dev

// ### verilog/sensor_host.sv
// Implementation choice: strobed register access.
`timescale 1ns/1ps
// Function
// - write 0x0a to 0x30 to convert
// - poll 0x30 until start flag clears
// - optionally wait 20 ms instead of polling
// - read 0x06..0x08 into 24-bit pressure
// - pressure bytes ordered high, mid, low
// - pressure top bit is two's complement sign
// - pascals equal signed count over divisor
// - divisor chosen by span, 32 to 8192
// - temperature is signed 16 bits at 0x09/0x0a
// - temperature count is high*256 plus low
// - celsius equals signed count over 256
// - start flag launches, clears at conversion end
// - select 010 means temperature then pressure
// - slave address is 0x6d
module sensor_host #(
	parameter int WAIT_CYCLES = sensor_pkg::WAIT_CYC
) (
	// system
	input  wire logic        clock,
	input  wire logic        rst,
	// software port
	input  wire logic [4:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [31:0] rdata,
	// two-wire link
	sensor_link_if.host      link
);
	sensor_pkg::c_state_t cst_q;
	sensor_pkg::b_state_t bst_q;
	sensor_pkg::op_t      op;
	logic        tick;
	logic [1:0]  ph_q;
	logic [3:0]  bit_q;
	logic [2:0]  step_q;
	logic [7:0]  sh_q;
	logic [7:0]  rx_q;
	logic        xgo_q;
	logic        xrd_q;
	logic        xdone_q;
	logic        xnack_q;
	logic [7:0]  xreg_q;
	logic        scl_oe_q;
	logic        sda_oe_q;
	logic [31:0] wait_q;
	logic [2:0]  ridx_q;
	logic [39:0] bytes_q;
	logic        wait_mode_q;
	logic [3:0]  shift_q;
	logic        done_q;
	logic        nack_q;
	logic [31:0] ppa_q;
	logic [31:0] rdata_q;

	// ----------------------------------------------------------------
	// quarter-bit enable
	// ----------------------------------------------------------------
	tick_gen #(
		.DIV   (sensor_pkg::QUARTER_CYC)
	) u_tick (
		.clock (clock),
		.rst   (rst),
		.tick  (tick)
	);

	// ----------------------------------------------------------------
	// decoding
	// ----------------------------------------------------------------
	wire        ctrl_wr   = wr && addr == sensor_pkg::A_CTRL;
	wire        sts_wr    = wr && addr == sensor_pkg::A_STATUS;
	wire        go        = ctrl_wr && wdata[sensor_pkg::CTRL_GO];
	wire        busy      = cst_q != sensor_pkg::C_IDLE;
	wire        last_bit  = bit_q == 4'd8;
	wire        is_bits   = op == sensor_pkg::OP_TX || op == sensor_pkg::OP_RX;
	wire [2:0]  stop_step = xrd_q ? 3'd6 : 3'd4;
	wire [2:0]  nstep     = xnack_q ? stop_step : step_q + 3'd1;
	wire        op_end    = tick && ph_q == 2'd3 && (!is_bits || last_bit);
	wire        fail      = xdone_q && xnack_q;
	wire        done_set  = cst_q == sensor_pkg::C_END || fail;
	wire [23:0] praw      = bytes_q[39:16];
	wire [15:0] traw      = bytes_q[15:0];
	wire [31:0] pfull     = {{8{praw[23]}}, praw};
	wire [31:0] tfull     = {{16{traw[15]}}, traw};
	wire [31:0] tdeg      = $signed(tfull) >>> 8;
	wire [31:0] rmux      =
		addr == sensor_pkg::A_CTRL   ? {26'h0, shift_q, wait_mode_q, 1'b0} :
		addr == sensor_pkg::A_STATUS ? {29'h0, nack_q, done_q, busy} :
		addr == sensor_pkg::A_PRAW   ? {8'h00, praw} :
		addr == sensor_pkg::A_PPA    ? ppa_q :
		addr == sensor_pkg::A_TRAW   ? {16'h0000, traw} :
		addr == sensor_pkg::A_TDEG   ? tdeg :
		32'h0000_0000;

	assign op = sensor_pkg::op_of(xrd_q, step_q);

	// ----------------------------------------------------------------
	// bit engine
	// ----------------------------------------------------------------
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			bst_q    <= sensor_pkg::B_IDLE;
			ph_q     <= 2'd0;
			bit_q    <= 4'd0;
			step_q   <= 3'd0;
			sh_q     <= 8'h00;
			rx_q     <= 8'h00;
			xdone_q  <= 1'b0;
			xnack_q  <= 1'b0;
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
		end else begin
			xdone_q <= 1'b0;
			case (bst_q)
				sensor_pkg::B_IDLE: if (xgo_q) begin
					bst_q   <= sensor_pkg::B_RUN;
					ph_q    <= 2'd0;
					bit_q   <= 4'd0;
					step_q  <= 3'd0;
					xnack_q <= 1'b0;
				end
				sensor_pkg::B_RUN: if (tick) begin
					ph_q <= ph_q + 2'd1;
					case (op)
						// also serves as the repeated start of a read
						sensor_pkg::OP_START: case (ph_q)
							2'd0: begin
								scl_oe_q <= 1'b1;
								sda_oe_q <= 1'b0;
							end
							2'd1: scl_oe_q <= 1'b0;
							2'd2: sda_oe_q <= 1'b1;
							default: scl_oe_q <= 1'b1;
						endcase
						sensor_pkg::OP_STOP: case (ph_q)
							2'd0: begin
								scl_oe_q <= 1'b1;
								sda_oe_q <= 1'b1;
							end
							2'd1: scl_oe_q <= 1'b0;
							2'd2: sda_oe_q <= 1'b0;
							default: begin
								bst_q   <= sensor_pkg::B_IDLE;
								xdone_q <= 1'b1;
							end
						endcase
						default: case (ph_q)
							2'd0: begin
								scl_oe_q <= 1'b1;
								sda_oe_q <= !last_bit && !sh_q[7]
									&& op == sensor_pkg::OP_TX;
							end
							2'd1: scl_oe_q <= 1'b0;
							2'd2: if (!last_bit)
								sh_q <= {sh_q[6:0], link.sda};
							else if (op == sensor_pkg::OP_RX)
								rx_q <= sh_q;
							else if (link.sda)
								xnack_q <= 1'b1;
							default: begin
								scl_oe_q <= 1'b1;
								bit_q    <= bit_q + 4'd1;
							end
						endcase
					endcase
					if (op_end) begin
						step_q <= nstep;
						bit_q  <= 4'd0;
						sh_q   <= sensor_pkg::tx_byte(xrd_q, nstep,
							xreg_q);
					end
				end
				default: bst_q <= sensor_pkg::B_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// readout sequence
	// ----------------------------------------------------------------
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cst_q   <= sensor_pkg::C_IDLE;
			xgo_q   <= 1'b0;
			xrd_q   <= 1'b0;
			xreg_q  <= sensor_pkg::REG_CMD;
			wait_q  <= 32'h0000_0000;
			ridx_q  <= 3'd0;
			bytes_q <= 40'h00_0000_0000;
			ppa_q   <= 32'h0000_0000;
		end else begin
			xgo_q <= 1'b0;
			case (cst_q)
				sensor_pkg::C_IDLE: if (go) begin
					cst_q  <= sensor_pkg::C_CMD;
					xgo_q  <= 1'b1;
					xrd_q  <= 1'b0;
					xreg_q <= sensor_pkg::REG_CMD;
				end
				sensor_pkg::C_CMD: if (fail)
					cst_q <= sensor_pkg::C_IDLE;
				else if (xdone_q && wait_mode_q) begin
					cst_q  <= sensor_pkg::C_WAIT;
					wait_q <= 32'h0000_0000;
				end else if (xdone_q) begin
					cst_q <= sensor_pkg::C_POLL;
					xgo_q <= 1'b1;
					xrd_q <= 1'b1;
				end
				sensor_pkg::C_WAIT: if (wait_q == 32'(WAIT_CYCLES - 1)) begin
					cst_q  <= sensor_pkg::C_READ;
					xgo_q  <= 1'b1;
					xrd_q  <= 1'b1;
					xreg_q <= sensor_pkg::REG_P_HIGH;
					ridx_q <= 3'd0;
				end else
					wait_q <= wait_q + 32'h0000_0001;
				sensor_pkg::C_POLL: if (fail)
					cst_q <= sensor_pkg::C_IDLE;
				else if (xdone_q && !rx_q[sensor_pkg::SCO_BIT]) begin
					cst_q  <= sensor_pkg::C_READ;
					xgo_q  <= 1'b1;
					xreg_q <= sensor_pkg::REG_P_HIGH;
					ridx_q <= 3'd0;
				end else if (xdone_q)
					xgo_q <= 1'b1;
				sensor_pkg::C_READ: if (fail)
					cst_q <= sensor_pkg::C_IDLE;
				else if (xdone_q) begin
					bytes_q <= {bytes_q[31:0], rx_q};
					if (ridx_q == sensor_pkg::LAST_RESULT)
						cst_q <= sensor_pkg::C_END;
					else begin
						ridx_q <= ridx_q + 3'd1;
						xreg_q <= xreg_q + 8'h01;
						xgo_q  <= 1'b1;
					end
				end
				sensor_pkg::C_END: begin
					// arithmetic shift floors negative values
					ppa_q <= $signed(pfull) >>> shift_q;
					cst_q <= sensor_pkg::C_IDLE;
				end
				default: cst_q <= sensor_pkg::C_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// software registers
	// ----------------------------------------------------------------
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wait_mode_q <= 1'b0;
			shift_q     <= sensor_pkg::SHIFT_RST;
			done_q      <= 1'b0;
			nack_q      <= 1'b0;
			rdata_q     <= 32'h0000_0000;
		end else begin
			if (ctrl_wr) begin
				wait_mode_q <= wdata[sensor_pkg::CTRL_WAIT];
				shift_q     <= wdata[sensor_pkg::CTRL_SH +: 4];
			end
			// a new event wins over a clear in the same cycle
			done_q  <= done_set
				|| (done_q && !(sts_wr && wdata[sensor_pkg::ST_DONE]));
			nack_q  <= fail
				|| (nack_q && !(sts_wr && wdata[sensor_pkg::ST_NACK]));
			rdata_q <= rd ? rmux : 32'h0000_0000;
		end
	end

	assign rdata         = rdata_q;
	assign link.h_scl_o  = 1'b0;
	assign link.h_sda_o  = 1'b0;
	assign link.h_scl_oe = scl_oe_q;
	assign link.h_sda_oe = sda_oe_q;
endmodule : sensor_host

// ### sim/pressure_temp_readout_sequence_sva.sv
`timescale 1ns/1ps
module pressure_temp_readout_sequence_sva (
	// system
	input wire logic clock,
	input wire logic rst,
	// two-wire link
	input wire logic scl,
	input wire logic sda,
	input wire logic h_scl_oe,
	input wire logic h_sda_oe,
	input wire logic d_sda_oe
);
	localparam logic [15:0] QTR  = 16'(sensor_pkg::QUARTER_CYC);
	localparam logic [15:0] HALF = 16'(2 * sensor_pkg::QUARTER_CYC);
	logic [15:0] hi_q;
	logic [15:0] lo_q;
	logic [15:0] hi_d;
	logic [15:0] lo_d;
	// ----------------------------------------------------------------
	// level run counters
	// ----------------------------------------------------------------
	// saturate so a long idle bus cannot wrap the count
	assign hi_d = !scl ? 16'h0000 : (&hi_q ? hi_q : hi_q + 16'h0001);
	assign lo_d = scl ? 16'h0000 : (&lo_q ? lo_q : lo_q + 16'h0001);
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			hi_q <= 16'h0000;
			lo_q <= 16'h0000;
		end else begin
			hi_q <= hi_d;
			lo_q <= lo_d;
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	// ----------------------------------------------------------------
	// link timing and framing
	// ----------------------------------------------------------------
	// the delays below assume a quarter phase of 30 clocks
	a_scl_high_time: assert property (
		$fell(scl) |-> hi_q >= HALF) else $error("scl high too short");
	a_scl_low_time: assert property (
		$rose(scl) |-> lo_q == QTR || lo_q == HALF)
		else $error("scl low time wrong");
	a_start_hold: assert property (
		$fell(sda) && scl |-> ##29 scl ##1 !scl)
		else $error("start not held one phase");
	a_stop_release: assert property (
		$rose(sda) && scl |-> ##1 (scl && sda) [*8])
		else $error("bus not free after stop");
	a_data_stable: assert property (
		$rose(scl) |-> ##1 $stable(sda) [*8])
		else $error("sda moved while scl high");
	a_dev_sda_change: assert property (
		$changed(d_sda_oe) |-> !scl) else $error("device drove sda late");
	a_host_sda_change: assert property (
		$changed(h_sda_oe) && scl |-> $past(scl) && $past(scl, 20))
		else $error("host moved sda in data phase");
	a_release_reset: assert property (
		$fell(rst) |-> !h_scl_oe && !h_sda_oe && !d_sda_oe)
		else $error("lines driven after reset");
endmodule : pressure_temp_readout_sequence_sva

// ### sim/pressure_temp_readout_sequence_test.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
	miscompares++; $display("CHECK FAILED %0t got %h exp %h", \
	$time, g, e); end end
module pressure_temp_readout_sequence_test;
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic [4:0]  addr = 5'h00;
	logic [31:0] wdata = 32'h0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [31:0] rdata;
	logic [31:0] rdata2;
	logic [23:0] p_in = 24'h0;
	logic [15:0] t_in = 16'h0;
	logic        sco_flag;
	logic [23:0] p_exp;
	logic [15:0] t_exp;
	logic [3:0]  sh;
	logic [31:0] st;
	logic [31:0] st2;
	logic [7:0]  bytes[$];
	logic [7:0]  mon_sh = 8'h00;
	int          bitc = 0;
	int          n;
	int          m;
	logic [23:0] trio;
	logic [39:0] pt;
	logic        scl_p = 1'b1;
	logic        sda_p = 1'b1;
	int          miscompares = 0;
	int          checks_done = 0;
	sensor_link_if link ();
	sensor_link_if link2 ();
	// second host faces an absent device: nothing ever acknowledges
	assign link2.d_sda_o = 1'b0;
	assign link2.d_sda_oe = 1'b0;
	always #12.5 clock = ~clock;
	sensor_host #(.WAIT_CYCLES(300)) u_sensor_host (.clock(clock),
		.rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .link(link));
	sensor_host #(.WAIT_CYCLES(300)) u_sensor_host_2 (.clock(clock),
		.rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata2), .link(link2));
	sensor_dev u_sensor_dev (.clock(clock), .rst(rst), .link(link),
		.pressure_in(p_in), .temperature_in(t_in), .sco_flag(sco_flag));
	pressure_temp_readout_sequence_sva u_pressure_temp_readout_sequence_sva (
		.clock(clock), .rst(rst), .scl(link.scl), .sda(link.sda),
		.h_scl_oe(link.h_scl_oe), .h_sda_oe(link.h_sda_oe),
		.d_sda_oe(link.d_sda_oe));
	// ----------------------------------------------------------------
	// byte monitor on the wire, sampled away from the launch edge
	// ----------------------------------------------------------------
	always @(negedge clock) begin
		if (scl_p && link.scl && sda_p && !link.sda)
			bitc = 0;
		else if (!scl_p && link.scl) begin
			if (bitc < 8)
				mon_sh = {mon_sh[6:0], link.sda};
			bitc = (bitc == 8) ? 0 : bitc + 1;
			if (bitc == 8)
				bytes.push_back(mon_sh);
		end
		scl_p = link.scl;
		sda_p = link.sda;
	end
	// ----------------------------------------------------------------
	// software port and expectations
	// ----------------------------------------------------------------
	task automatic sw_wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask : sw_wr
	task automatic sw_rd(input logic [4:0] a, output logic [31:0] d,
		output logic [31:0] d2);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1;
		d = rdata;
		d2 = rdata2;
	endtask : sw_rd
	task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [31:0] d2;
		sw_rd(a, d, d2);
		`CHK(d, e)
	endtask : rd_chk
	function automatic logic [31:0] exp_pa(logic [23:0] p, logic [3:0] s);
		logic signed [31:0] v;
		v = {{8{p[23]}}, p};
		exp_pa = v >>> s;
	endfunction : exp_pa
	function automatic logic [31:0] exp_deg(logic [15:0] t);
		logic signed [31:0] v;
		v = {{16{t[15]}}, t};
		exp_deg = v >>> 8;
	endfunction : exp_deg
	// waits for done, then checks registers and the five reads on the wire
	task automatic results();
		st = 32'h0;
		for (n = 0; n < 300 && st[1] !== 1'b1; n++) begin
			repeat (200) @(posedge clock);
			sw_rd(sensor_pkg::A_STATUS, st, st2);
		end
		`CHK(st, 32'h2)
		`CHK(st2, 32'h6)
		rd_chk(sensor_pkg::A_PRAW, {8'h0, p_exp});
		rd_chk(sensor_pkg::A_PPA, exp_pa(p_exp, sh));
		rd_chk(sensor_pkg::A_TRAW, {16'h0, t_exp});
		rd_chk(sensor_pkg::A_TDEG, exp_deg(t_exp));
		sw_wr(sensor_pkg::A_STATUS, 32'h6);
		rd_chk(sensor_pkg::A_STATUS, 32'h0);
		n = bytes.size();
		pt = {p_exp, t_exp};
		for (int k = 0; k < 5; k++) begin
			trio = {bytes[n-20+4*k], bytes[n-19+4*k], bytes[n-18+4*k]};
			`CHK(trio, {8'hda, 8'(6 + k), 8'hdb})
			`CHK(bytes[n-17+4*k], 8'(pt >> (32 - 8 * k)))
		end
	endtask : results
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : conclude
	initial begin
		repeat (90000) @(posedge clock);
		miscompares++;
		conclude();
	end
	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(32'h66ef3212));
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		repeat (400) @(posedge clock);
		rd_chk(sensor_pkg::A_CTRL, {26'h0, sensor_pkg::SHIFT_RST, 2'b00});
		rd_chk(sensor_pkg::A_STATUS, 32'h0);
		rd_chk(5'h1c, 32'h0);
		$display("test reset state done");
		// negative pressure corner, random temperature and divisor
		p_in <= {1'b1, 23'($urandom)};
		t_in <= 16'($urandom);
		sh = 4'(5 + $urandom_range(8));
		sw_wr(sensor_pkg::A_CTRL, {26'h0, sh, 2'b01});
		// second go while busy must not restart the sequence
		sw_wr(sensor_pkg::A_CTRL, {26'h0, sh, 2'b01});
		rd_chk(sensor_pkg::A_STATUS, 32'h1);
		for (n = 0; n < 40000 && sco_flag !== 1'b1; n++)
			@(posedge clock);
		`CHK(sco_flag, 1'b1)
		for (n = 0; n < 1000 && sco_flag !== 1'b0; n++)
			@(posedge clock);
		`CHK(sco_flag, 1'b0)
		p_exp = p_in;
		t_exp = t_in;
		// later input changes must not reach the latched results
		p_in <= 24'($urandom);
		t_in <= 16'($urandom);
		results();
		$display("test measurement done");
		`CHK(bytes[0], 8'hda)
		`CHK(bytes[1], sensor_pkg::REG_CMD)
		`CHK(bytes[2], sensor_pkg::CMD_COMBINED)
		trio = {bytes[3], bytes[4], bytes[5]};
		`CHK(trio, 24'hda30db)
		// the last poll must have seen the start flag cleared
		`CHK(bytes[n-21], 8'h02)
		`CHK(n % 4, 3)
		$display("test wire bytes done");
		// fixed wait instead of polling, positive pressure corner
		m = n;
		p_in <= {1'b0, 23'($urandom)};
		t_in <= 16'($urandom);
		sh = 4'(5 + $urandom_range(8));
		sw_wr(sensor_pkg::A_CTRL, {26'h0, sh, 2'b11});
		rd_chk(sensor_pkg::A_CTRL, {26'h0, sh, 2'b10});
		p_exp = p_in;
		t_exp = t_in;
		results();
		// no poll transaction: command, then five reads
		`CHK(n - m, 23)
		$display("test fixed wait done");
		conclude();
	end
endmodule : pressure_temp_readout_sequence_test
